// ### csum_offload.sv
// receive and transmit checksum offload engines with axi4-lite control
//
// Design decisions made here: the AXI4-Lite register port and the address map.
`timescale 1ns/100ps
module csum_offload
	import csum_offload_pkg::*;
(
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// axi4-lite write
	input wire logic [7:0] s_axi_awaddr_i,
	input wire logic s_axi_awvalid_i,
	output logic s_axi_awready_o,
	input wire logic [31:0] s_axi_wdata_i,
	input wire logic [3:0] s_axi_wstrb_i,
	input wire logic s_axi_wvalid_i,
	output logic s_axi_wready_o,
	output logic [1:0] s_axi_bresp_o,
	output logic s_axi_bvalid_o,
	input wire logic s_axi_bready_i,
	// axi4-lite read
	input wire logic [7:0] s_axi_araddr_i,
	input wire logic s_axi_arvalid_i,
	output logic s_axi_arready_o,
	output logic [31:0] s_axi_rdata_o,
	output logic [1:0] s_axi_rresp_o,
	output logic s_axi_rvalid_o,
	input wire logic s_axi_rready_i,
	// receive stream from mac, to rx fifo
	input wire logic rx_in_valid_i,
	input wire rx_beat_t rx_in_i,
	output logic rx_out_valid_o,
	output rx_beat_t rx_out_o,
	// transmit command and bytes from host fifo
	input wire logic tx_cmd_valid_i,
	input wire tx_cmd_t tx_cmd_i,
	output logic tx_cmd_ready_o,
	input wire logic tx_in_valid_i,
	input wire tx_beat_t tx_in_i,
	output logic tx_in_ready_o,
	// transmit stream to mac
	output logic tx_out_valid_o,
	output tx_beat_t tx_out_o
);
	typedef enum logic [1:0] {RX_PASS, RX_APP_LO, RX_APP_HI} rx_state_t;
	typedef enum logic [2:0] {T_CMD, T_PASS, T_LOAD, T_FLUSH, T_WAIT, T_PLAY} tx_state_t;

	// register file
	logic [31:0] ctrl_reg;
	logic [15:0] vlan_reg;
	logic [15:0] rx_sum_last_reg;
	logic [15:0] tx_sum_last_reg;
	// axi slave state
	logic awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
	logic aw_full_reg, w_full_reg;
	logic [7:0] aw_addr_reg;
	logic [31:0] w_data_reg;
	logic [3:0] w_strb_reg;
	logic [1:0] bresp_reg, rresp_reg;
	logic [31:0] rdata_reg;
	// receive engine
	rx_state_t rx_state;
	logic [11:0] rx_cnt_reg, rx_type_pos_reg, rx_start_reg;
	logic [7:0] rx_type_hi_reg;
	logic [1:0] rx_tags_reg;
	logic [3:0][7:0] rx_dly_reg;
	logic rx_flush_reg, rx_out_valid_reg;
	logic [31:0] rx_status_reg;
	rx_beat_t rx_out_reg;
	logic rx_take, rx_enabled, rx_mode, rx_sum_valid;
	logic [15:0] rx_sum, rx_type;
	logic [11:0] rx_pos;
	// transmit engine
	tx_state_t tx_state;
	logic tx_cmd_ready_reg, tx_in_ready_reg, tx_out_valid_reg;
	tx_beat_t tx_out_reg;
	logic [11:0] tx_start_reg, tx_loc_reg, tx_cnt_reg, tx_len_reg, tx_rd_addr_reg, tx_rd_pos_reg;
	logic tx_rd_pend_reg, tx_rd_last_reg;
	logic [15:0] tx_csum_reg, tx_sum;
	logic [7:0] tx_ram_rdata;
	logic tx_cmd_take, tx_byte_take, tx_sum_valid, tx_do_sum;

	// byte-lane merge for partial writes
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
			if (strb[i])
				r[8*i +: 8] = wd[8*i +: 8];
		return r;
	endfunction

	// write channel: address and data taken in either order, one write in flight
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			awready_reg <= 1'b1;
			wready_reg <= 1'b1;
			aw_full_reg <= 1'b0;
			w_full_reg <= 1'b0;
			aw_addr_reg <= 8'h00;
			w_data_reg <= 32'h0000_0000;
			w_strb_reg <= 4'h0;
			bvalid_reg <= 1'b0;
			bresp_reg <= RESP_OKAY;
			ctrl_reg <= CTRL_RESET;
			vlan_reg <= VLAN_RESET;
		end
		else
		begin
			if (s_axi_awvalid_i && awready_reg)
			begin
				aw_addr_reg <= s_axi_awaddr_i;
				aw_full_reg <= 1'b1;
				awready_reg <= 1'b0;
			end
			if (s_axi_wvalid_i && wready_reg)
			begin
				w_data_reg <= s_axi_wdata_i;
				w_strb_reg <= s_axi_wstrb_i;
				w_full_reg <= 1'b1;
				wready_reg <= 1'b0;
			end
			if (aw_full_reg && w_full_reg && !bvalid_reg)
			begin
				aw_full_reg <= 1'b0;
				w_full_reg <= 1'b0;
				bvalid_reg <= 1'b1;
				bresp_reg <= RESP_OKAY;
				case (aw_addr_reg[7:2])
					CTRL_OFFSET[7:2]: ctrl_reg <= merge(ctrl_reg, w_data_reg, w_strb_reg) & CTRL_MASK;
					VLAN_OFFSET[7:2]: vlan_reg <= 16'(merge({16'h0000, vlan_reg}, w_data_reg,
						w_strb_reg));
					STAT_OFFSET[7:2]: bresp_reg <= RESP_OKAY; // read-only, write dropped
					default: bresp_reg <= RESP_SLVERR;
				endcase
			end
			if (bvalid_reg && s_axi_bready_i)
			begin
				bvalid_reg <= 1'b0;
				awready_reg <= 1'b1;
				wready_reg <= 1'b1;
			end
		end
	end

	// read channel: data one cycle after the address is taken
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			arready_reg <= 1'b1;
			rvalid_reg <= 1'b0;
			rdata_reg <= 32'h0000_0000;
			rresp_reg <= RESP_OKAY;
		end
		else if (s_axi_arvalid_i && arready_reg)
		begin
			arready_reg <= 1'b0;
			rvalid_reg <= 1'b1;
			rresp_reg <= RESP_OKAY;
			case (s_axi_araddr_i[7:2])
				CTRL_OFFSET[7:2]: rdata_reg <= ctrl_reg;
				VLAN_OFFSET[7:2]: rdata_reg <= {16'h0000, vlan_reg};
				STAT_OFFSET[7:2]: rdata_reg <= {tx_sum_last_reg, rx_sum_last_reg};
				default:
				begin
					rdata_reg <= 32'h0000_0000;
					rresp_reg <= RESP_SLVERR;
				end
			endcase
		end
		else if (rvalid_reg && s_axi_rready_i)
		begin
			rvalid_reg <= 1'b0;
			arready_reg <= 1'b1;
		end
	end

	// mode bits are used live; software must quiesce receive before changing them
	assign rx_enabled = ctrl_reg[RX_EN_BIT];
	assign rx_mode = ctrl_reg[RX_MODE_BIT];
	assign rx_take = rx_in_valid_i && (rx_state == RX_PASS);
	assign rx_type = {rx_type_hi_reg, rx_in_i.data};
	// position of the byte leaving the delay line; the last four never leave it
	assign rx_pos = rx_cnt_reg - FCS_LEN;
	assign rx_sum_valid = rx_take && rx_enabled && (rx_cnt_reg >= FCS_LEN)
		&& (rx_pos >= rx_start_reg);

	// byte count, fcs delay line and header parse
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			rx_cnt_reg <= 12'h000;
			rx_dly_reg <= '0;
			rx_type_pos_reg <= TYPE_POS_FIRST;
			rx_type_hi_reg <= 8'h00;
			rx_tags_reg <= 2'h0;
			rx_start_reg <= MAC_HDR_LEN;
		end
		else if (rx_take)
		begin
			rx_cnt_reg <= rx_in_i.last ? 12'h000 : rx_cnt_reg + 12'h001;
			rx_dly_reg <= {rx_dly_reg[2:0], rx_in_i.data};
			if (rx_cnt_reg == 12'h000)
			begin
				rx_type_pos_reg <= TYPE_POS_FIRST;
				rx_tags_reg <= 2'h0;
				rx_start_reg <= rx_mode ? START_UNKNOWN : MAC_HDR_LEN;
			end
			else if (rx_mode && rx_cnt_reg == rx_type_pos_reg)
				rx_type_hi_reg <= rx_in_i.data;
			else if (rx_mode && rx_cnt_reg == rx_type_pos_reg + 12'h001)
			begin
				if (rx_type == vlan_reg && rx_tags_reg < MAX_VLAN_TAGS)
				begin
					rx_tags_reg <= rx_tags_reg + 2'h1;
					rx_type_pos_reg <= rx_type_pos_reg + VLAN_TAG_LEN;
				end
				else if (rx_type < LEN_TYPE_MIN)
					rx_start_reg <= rx_type_pos_reg + TYPE_LEN + SNAP_HDR_LEN;
				else
					rx_start_reg <= rx_type_pos_reg + TYPE_LEN;
			end
		end
	end

	// receive accumulator; odd byte padded one cycle after the frame ends
	ones_sum_acc u_rx_sum (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.clear_i(rx_take && rx_cnt_reg == 12'h000),
		.byte_valid_i(rx_sum_valid),
		.byte_i(rx_dly_reg[3]),
		.flush_i(rx_flush_reg),
		.sum_o(rx_sum)
	);

	// output stream; the two appended bytes need three idle input cycles after a frame
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			rx_state <= RX_PASS;
			rx_out_valid_reg <= 1'b0;
			rx_out_reg <= '0;
			rx_flush_reg <= 1'b0;
			rx_status_reg <= 32'h0000_0000;
			rx_sum_last_reg <= 16'h0000;
		end
		else
		begin
			rx_out_valid_reg <= 1'b0;
			rx_flush_reg <= rx_take && rx_in_i.last;
			case (rx_state)
				RX_PASS:
				begin
					if (rx_in_valid_i)
					begin
						rx_out_valid_reg <= 1'b1;
						rx_out_reg <= rx_in_i;
						if (rx_in_i.last && rx_enabled)
						begin
							rx_out_reg.last <= 1'b0;
							rx_status_reg <= rx_in_i.status;
							rx_state <= RX_APP_LO;
						end
					end
				end
				RX_APP_LO:
				begin
					// wait out the flush so the odd byte is in the sum
					if (!rx_flush_reg)
					begin
						rx_out_valid_reg <= 1'b1;
						rx_out_reg.data <= rx_sum[7:0];
						rx_out_reg.last <= 1'b0;
						rx_state <= RX_APP_HI;
					end
				end
				RX_APP_HI:
				begin
					rx_out_valid_reg <= 1'b1;
					rx_out_reg.data <= rx_sum[15:8];
					rx_out_reg.last <= 1'b1;
					rx_out_reg.status <= rx_status_reg;
					rx_out_reg.status[RX_LEN_LSB +: RX_LEN_W] <=
						rx_status_reg[RX_LEN_LSB +: RX_LEN_W] + RX_APPEND_LEN;
					rx_sum_last_reg <= rx_sum;
					rx_state <= RX_PASS;
				end
				default: rx_state <= RX_PASS;
			endcase
		end
	end

	assign tx_cmd_take = tx_cmd_valid_i && tx_cmd_ready_reg;
	assign tx_byte_take = tx_in_valid_i && tx_in_ready_reg;
	assign tx_do_sum = tx_cmd_i.checksum_request && tx_cmd_i.first_segment
		&& ctrl_reg[TX_EN_BIT];
	assign tx_sum_valid = tx_byte_take && (tx_state == T_LOAD)
		&& (tx_cnt_reg >= tx_start_reg);

	// transmit accumulator, same procedure as receive
	ones_sum_acc u_tx_sum (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.clear_i(tx_cmd_take),
		.byte_valid_i(tx_sum_valid),
		.byte_i(tx_in_i.data),
		.flush_i(tx_state == T_FLUSH),
		.sum_o(tx_sum)
	);

	// store-and-forward buffer: the insert point may precede the end of the sum
	tx_pkt_ram u_tx_ram (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.we_i(tx_byte_take && tx_state == T_LOAD),
		.waddr_i(tx_cnt_reg[RAM_AW-1:0]),
		.wdata_i(tx_in_i.data),
		.raddr_i(tx_rd_addr_reg[RAM_AW-1:0]),
		.rdata_o(tx_ram_rdata)
	);

	// transmit sequencer; checksummed packets over the buffer depth wrap and are corrupted
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			tx_state <= T_CMD;
			tx_cmd_ready_reg <= 1'b1;
			tx_in_ready_reg <= 1'b0;
			tx_start_reg <= 12'h000;
			tx_loc_reg <= 12'h000;
			tx_cnt_reg <= 12'h000;
			tx_len_reg <= 12'h000;
			tx_rd_addr_reg <= 12'h000;
			tx_rd_pos_reg <= 12'h000;
			tx_rd_pend_reg <= 1'b0;
			tx_rd_last_reg <= 1'b0;
			tx_csum_reg <= 16'h0000;
			tx_sum_last_reg <= 16'h0000;
		end
		else
		begin
			tx_rd_pend_reg <= 1'b0;
			case (tx_state)
				T_CMD:
				begin
					if (tx_cmd_take)
					begin
						tx_cmd_ready_reg <= 1'b0;
						tx_in_ready_reg <= 1'b1;
						tx_start_reg <= tx_cmd_i.preamble[START_LSB +: PTR_W];
						tx_loc_reg <= tx_cmd_i.preamble[LOC_LSB +: PTR_W];
						tx_cnt_reg <= 12'h000;
						tx_state <= tx_do_sum ? T_LOAD : T_PASS;
					end
				end
				T_PASS:
				begin
					if (tx_byte_take && tx_in_i.last)
					begin
						tx_in_ready_reg <= 1'b0;
						tx_cmd_ready_reg <= 1'b1;
						tx_state <= T_CMD;
					end
				end
				T_LOAD:
				begin
					if (tx_byte_take)
					begin
						tx_cnt_reg <= tx_cnt_reg + 12'h001;
						if (tx_in_i.last)
						begin
							tx_in_ready_reg <= 1'b0;
							tx_len_reg <= tx_cnt_reg;
							tx_state <= T_FLUSH;
						end
					end
				end
				T_FLUSH: tx_state <= T_WAIT;
				T_WAIT:
				begin
					// complement only; a zero result stays zero
					tx_csum_reg <= ~tx_sum;
					tx_sum_last_reg <= ~tx_sum;
					tx_rd_addr_reg <= 12'h000;
					tx_state <= T_PLAY;
				end
				T_PLAY:
				begin
					tx_rd_pend_reg <= 1'b1;
					tx_rd_pos_reg <= tx_rd_addr_reg;
					tx_rd_last_reg <= (tx_rd_addr_reg == tx_len_reg);
					tx_rd_addr_reg <= tx_rd_addr_reg + 12'h001;
					if (tx_rd_addr_reg == tx_len_reg)
					begin
						tx_cmd_ready_reg <= 1'b1;
						tx_state <= T_CMD;
					end
				end
				default: tx_state <= T_CMD;
			endcase
		end
	end

	// stream to mac: pass-through bytes or buffered bytes with the insert
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			tx_out_valid_reg <= 1'b0;
			tx_out_reg <= '0;
		end
		else if (tx_state == T_PASS && tx_byte_take)
		begin
			tx_out_valid_reg <= 1'b1;
			tx_out_reg <= tx_in_i;
		end
		else if (tx_rd_pend_reg)
		begin
			tx_out_valid_reg <= 1'b1;
			tx_out_reg.last <= tx_rd_last_reg;
			if (tx_rd_pos_reg == tx_loc_reg)
				tx_out_reg.data <= tx_csum_reg[7:0];
			else if (tx_rd_pos_reg == tx_loc_reg + 12'h001)
				tx_out_reg.data <= tx_csum_reg[15:8];
			else
				tx_out_reg.data <= tx_ram_rdata;
		end
		else
			tx_out_valid_reg <= 1'b0;
	end

	assign s_axi_awready_o = awready_reg;
	assign s_axi_wready_o = wready_reg;
	assign s_axi_bvalid_o = bvalid_reg;
	assign s_axi_bresp_o = bresp_reg;
	assign s_axi_arready_o = arready_reg;
	assign s_axi_rvalid_o = rvalid_reg;
	assign s_axi_rdata_o = rdata_reg;
	assign s_axi_rresp_o = rresp_reg;
	assign rx_out_valid_o = rx_out_valid_reg;
	assign rx_out_o = rx_out_reg;
	assign tx_cmd_ready_o = tx_cmd_ready_reg;
	assign tx_in_ready_o = tx_in_ready_reg;
	assign tx_out_valid_o = tx_out_valid_reg;
	assign tx_out_o = tx_out_reg;
endmodule

// ### csum_offload_pkg.sv
// constants and carrier types for the ethernet checksum offload engines
package csum_offload_pkg;
	// register map, byte addresses
	localparam logic [7:0] CTRL_OFFSET = 8'h00;
	localparam logic [7:0] VLAN_OFFSET = 8'h04;
	localparam logic [7:0] STAT_OFFSET = 8'h08;
	// offload_control_reg fields
	localparam int RX_EN_BIT = 0;
	localparam int RX_MODE_BIT = 1;
	localparam int TX_EN_BIT = 16;
	localparam logic [31:0] CTRL_MASK = 32'h0001_0003;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
	localparam logic [15:0] VLAN_RESET = 16'h8100;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// frame layout
	localparam logic [11:0] MAC_HDR_LEN = 12'h00e;
	localparam logic [11:0] TYPE_POS_FIRST = 12'h00c;
	localparam logic [11:0] VLAN_TAG_LEN = 12'h004;
	localparam logic [11:0] SNAP_HDR_LEN = 12'h008;
	localparam logic [11:0] TYPE_LEN = 12'h002;
	localparam logic [11:0] FCS_LEN = 12'h004;
	localparam logic [11:0] START_UNKNOWN = 12'hfff;
	localparam logic [15:0] LEN_TYPE_MIN = 16'h0600;
	localparam logic [1:0] MAX_VLAN_TAGS = 2'h2;
	// receive status word length field
	localparam int RX_LEN_LSB = 16;
	localparam int RX_LEN_W = 14;
	localparam logic [13:0] RX_APPEND_LEN = 14'h0002;
	// transmit preamble fields
	localparam int START_LSB = 0;
	localparam int LOC_LSB = 16;
	localparam int PTR_W = 12;
	// transmit store-and-forward buffer
	localparam int RAM_AW = 11;
	localparam int RAM_DEPTH = 2048;

	typedef struct packed {
		logic [7:0] data;
		logic last;
		logic [31:0] status;
	} rx_beat_t;

	typedef struct packed {
		logic first_segment;
		logic checksum_request;
		logic [31:0] preamble;
	} tx_cmd_t;

	typedef struct packed {
		logic [7:0] data;
		logic last;
	} tx_beat_t;
endpackage

// ### ones_sum_acc.sv
// byte-fed 16-bit end-around-carry accumulator
`timescale 1ns/100ps
module ones_sum_acc
	import csum_offload_pkg::*;
(
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// byte feed
	input wire logic clear_i,
	input wire logic byte_valid_i,
	input wire logic [7:0] byte_i,
	input wire logic flush_i,
	// result
	output logic [15:0] sum_o
);
	logic [7:0] low_reg;
	logic odd_reg;
	logic [15:0] sum_reg;

	// add with the carry folded back in; a second carry cannot occur
	function automatic logic [15:0] fold(input logic [15:0] a, input logic [15:0] b);
		logic [16:0] s;
		s = {1'b0, a} + {1'b0, b};
		return s[15:0] + {15'h0000, s[16]};
	endfunction

	// earlier byte parked as low half until its partner arrives
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			low_reg <= 8'h00;
			odd_reg <= 1'b0;
			sum_reg <= 16'h0000;
		end
		else if (clear_i)
		begin
			odd_reg <= 1'b0;
			sum_reg <= 16'h0000;
		end
		else if (byte_valid_i)
		begin
			if (!odd_reg)
			begin
				low_reg <= byte_i;
				odd_reg <= 1'b1;
			end
			else
			begin
				sum_reg <= fold(sum_reg, {byte_i, low_reg});
				odd_reg <= 1'b0;
			end
		end
		else if (flush_i && odd_reg)
		begin
			sum_reg <= fold(sum_reg, {8'h00, low_reg});
			odd_reg <= 1'b0;
		end
	end

	assign sum_o = sum_reg;
endmodule

// ### tx_pkt_ram.sv
// transmit packet buffer with registered read data
`timescale 1ns/100ps
module tx_pkt_ram
	import csum_offload_pkg::*;
(
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// write side
	input wire logic we_i,
	input wire logic [RAM_AW-1:0] waddr_i,
	input wire logic [7:0] wdata_i,
	// read side
	input wire logic [RAM_AW-1:0] raddr_i,
	output logic [7:0] rdata_o
);
	logic [7:0] mem [RAM_DEPTH];
	logic [7:0] rdata_reg;

	// array left unreset so it maps onto block memory
	always_ff @(posedge clk_i)
	begin
		if (we_i)
			mem[waddr_i] <= wdata_i;
	end

	// read data one cycle after the address
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			rdata_reg <= 8'h00;
		else
			rdata_reg <= mem[raddr_i];
	end

	assign rdata_o = rdata_reg;
endmodule

// ### csum_offload_checker.sv
// port-level assertions for the checksum offload block
`timescale 1ns/100ps
module csum_offload_checker
	import csum_offload_pkg::*;
(
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// axi4-lite handshakes
	input wire logic s_axi_awvalid_i,
	input wire logic s_axi_awready_o,
	input wire logic s_axi_wvalid_i,
	input wire logic s_axi_wready_o,
	input wire logic [1:0] s_axi_bresp_o,
	input wire logic s_axi_bvalid_o,
	input wire logic s_axi_bready_i,
	input wire logic s_axi_arvalid_i,
	input wire logic s_axi_arready_o,
	input wire logic [31:0] s_axi_rdata_o,
	input wire logic s_axi_rvalid_o,
	input wire logic s_axi_rready_i,
	// streams
	input wire logic rx_in_valid_i,
	input wire rx_beat_t rx_in_i,
	input wire logic rx_out_valid_o,
	input wire rx_beat_t rx_out_o,
	input wire logic tx_cmd_valid_i,
	input wire logic tx_cmd_ready_o
);
	// single domain, everything off while reset is low
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rst_n_i);

	a_write_answer: assert property (s_axi_awvalid_i && s_axi_awready_o &&
		s_axi_wvalid_i && s_axi_wready_o |-> ##2 s_axi_bvalid_o)
		else $error("write response not two cycles after take");
	a_bresp_hold: assert property (s_axi_bvalid_o && !s_axi_bready_i |=>
		s_axi_bvalid_o && $stable(s_axi_bresp_o))
		else $error("write response dropped early");
	a_write_busy: assert property (s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o)
		else $error("write channels ready during response");
	a_read_answer: assert property (s_axi_arvalid_i && s_axi_arready_o |=>
		s_axi_rvalid_o && !s_axi_arready_o)
		else $error("read data not one cycle after take");
	a_rdata_hold: assert property (s_axi_rvalid_o && !s_axi_rready_i |=>
		s_axi_rvalid_o && $stable(s_axi_rdata_o))
		else $error("read data changed before taken");
	a_rx_byte_latency: assert property (rx_in_valid_i |=> rx_out_valid_o)
		else $error("receive byte not passed next cycle");
	a_rx_byte_copy: assert property (rx_in_valid_i && !rx_in_i.last |=>
		rx_out_o.data == $past(rx_in_i.data) && !rx_out_o.last)
		else $error("receive byte altered");
	a_rx_len_grow: assert property ((rx_in_valid_i && rx_in_i.last)
		##1 (rx_out_valid_o && !rx_out_o.last) ##3 (rx_out_valid_o && rx_out_o.last)
		|-> rx_out_o.status[29:16] == $past(rx_in_i.status[29:16], 4) + 14'h0002)
		else $error("status length not grown by two");
	a_tx_cmd_once: assert property (tx_cmd_valid_i && tx_cmd_ready_o |=> !tx_cmd_ready_o)
		else $error("second command taken inside a packet");
endmodule

// ### mac_side_model.sv
// mac-side model: feeds receive frames and collects transmit bytes
`timescale 1ns/100ps
module mac_side_model
	import csum_offload_pkg::*;
(
	// clock
	input wire logic clk_i,
	// receive stream toward the engine
	output logic rx_valid_o,
	output rx_beat_t rx_beat_o,
	// transmit stream from the engine
	input wire logic tx_valid_i,
	input wire tx_beat_t tx_beat_i
);
	logic [7:0] tx_seen[$];
	int tx_last_idx = -1;

	initial
	begin
		rx_valid_o = 1'b0;
		rx_beat_o = '0;
	end

	// one byte a cycle, no back-pressure; idle data flips so stale bytes never look valid
	task automatic send_frame(input logic [7:0] b[$], input logic [31:0] st);
		foreach (b[i])
		begin
			@(posedge clk_i);
			rx_valid_o <= 1'b1;
			rx_beat_o <= {b[i], i == b.size() - 1, st};
		end
		@(posedge clk_i);
		rx_valid_o <= 1'b0;
		rx_beat_o.data <= ~b[b.size() - 1];
		repeat (4) @(posedge clk_i);
	endtask

	// transmit sink
	always @(posedge clk_i)
	begin
		if (tx_valid_i === 1'b1 && tx_beat_i.last === 1'b1)
			tx_last_idx = tx_seen.size();
		if (tx_valid_i === 1'b1)
			tx_seen.push_back(tx_beat_i.data);
	end
endmodule

// ### csum_offload_bench.sv
// self-checking bench for the checksum offload block
`timescale 1ns/100ps
module csum_offload_bench
	import csum_offload_pkg::*;
;
	typedef struct packed {
		logic [7:0] addr;
		logic [31:0] wdata;
		logic [31:0] rdata;
		logic [1:0] resp;
	} reg_row_t;
	logic clk_i = 1'b0;
	logic rst_n_i;
	logic [7:0] s_axi_awaddr_i, s_axi_araddr_i;
	logic [31:0] s_axi_wdata_i, s_axi_rdata_o;
	logic [3:0] s_axi_wstrb_i;
	logic [1:0] s_axi_bresp_o, s_axi_rresp_o;
	logic s_axi_awvalid_i, s_axi_awready_o, s_axi_wvalid_i, s_axi_wready_o, s_axi_bvalid_o;
	logic s_axi_bready_i, s_axi_arvalid_i, s_axi_arready_o, s_axi_rvalid_o, s_axi_rready_i;
	logic rx_in_valid_i, rx_out_valid_o, tx_cmd_valid_i, tx_cmd_ready_o;
	logic tx_in_valid_i, tx_in_ready_o, tx_out_valid_o;
	rx_beat_t rx_in_i, rx_out_o;
	tx_cmd_t tx_cmd_i;
	tx_beat_t tx_in_i, tx_out_o;
	int n_errors = 0;
	int n_compared = 0;
	logic [7:0] rx_seen[$];
	logic [7:0] f[$];
	logic [31:0] rx_stat;
	reg_row_t rows[5];

	csum_offload uut (.*);
	mac_side_model mac (.clk_i(clk_i), .rx_valid_o(rx_in_valid_i), .rx_beat_o(rx_in_i),
		.tx_valid_i(tx_out_valid_o), .tx_beat_i(tx_out_o));

	// 200 mhz clock
	always #2.5 clk_i = ~clk_i;

	// receive-side sink
	always @(posedge clk_i)
	begin
		if (rx_out_valid_o === 1'b1)
			rx_seen.push_back(rx_out_o.data);
		if (rx_out_valid_o === 1'b1 && rx_out_o.last === 1'b1)
			rx_stat = rx_out_o.status;
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic report_and_stop;
		$display("compared %0d, errors %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// ready is raised only after valid is seen, so the hold path is exercised
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		s_axi_awaddr_i <= a;
		s_axi_wdata_i <= d;
		s_axi_awvalid_i <= 1'b1;
		s_axi_wvalid_i <= 1'b1;
		do
		begin
			@(posedge clk_i);
			if (s_axi_awready_o === 1'b1) s_axi_awvalid_i <= 1'b0;
			if (s_axi_wready_o === 1'b1) s_axi_wvalid_i <= 1'b0;
			s_axi_bready_i <= s_axi_bvalid_o === 1'b1 && s_axi_bready_i !== 1'b1;
		end
		while (!(s_axi_bvalid_o === 1'b1 && s_axi_bready_i === 1'b1));
		check(s_axi_bresp_o, er);
	endtask

	task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		s_axi_araddr_i <= a;
		s_axi_arvalid_i <= 1'b1;
		do
		begin
			@(posedge clk_i);
			if (s_axi_arready_o === 1'b1) s_axi_arvalid_i <= 1'b0;
			s_axi_rready_i <= s_axi_rvalid_o === 1'b1 && s_axi_rready_i !== 1'b1;
		end
		while (!(s_axi_rvalid_o === 1'b1 && s_axi_rready_i === 1'b1));
		check(s_axi_rdata_o, ed);
		check(s_axi_rresp_o, er);
	endtask

	function automatic void mk(input int n);
		f.delete();
		for (int i = 0; i < n; i++) f.push_back(8'(i * 7 + 3));
	endfunction

	// end-around-carry sum of f[a..b-1], later byte of a pair high
	function automatic logic [15:0] osum(input int a, input int b);
		logic [16:0] t;
		t = '0;
		for (int i = a; i < b; i += 2)
		begin
			t = 17'(t[15:0]) + 17'({((i + 1 < b) ? f[i + 1] : 8'h00), f[i]});
			t = 17'(t[15:0]) + 17'(t[16]);
		end
		return t[15:0];
	endfunction

	task automatic rx_case(input int st, input logic en);
		logic [7:0] exp[$];
		logic [15:0] s;
		exp = f;
		s = osum(st, f.size() - 4);
		if (en) exp = {exp, s[7:0], s[15:8]};
		rx_seen.delete();
		mac.send_frame(f, {2'b00, 14'(f.size()), 16'h0000});
		repeat (8) @(posedge clk_i);
		check(rx_seen.size(), exp.size());
		foreach (exp[i]) check(rx_seen[i], exp[i]);
		check(rx_stat[29:16], exp.size());
	endtask

	// host side: command, then bytes held until ready, then idle data flips
	task automatic tx_case(input logic [1:0] fc, input int st, input int lc, input logic ins);
		logic [7:0] exp[$];
		logic [15:0] s;
		exp = f;
		s = ~osum(st, f.size());
		if (ins) exp[lc] = s[7:0];
		if (ins) exp[lc + 1] = s[15:8];
		mac.tx_seen.delete();
		mac.tx_last_idx = -1;
		tx_cmd_i <= {fc, 4'h0, 12'(lc), 4'h0, 12'(st)};
		tx_cmd_valid_i <= 1'b1;
		do @(posedge clk_i); while (tx_cmd_ready_o !== 1'b1);
		tx_cmd_valid_i <= 1'b0;
		foreach (f[i])
		begin
			tx_in_valid_i <= 1'b1;
			tx_in_i <= {f[i], i == f.size() - 1};
			do @(posedge clk_i); while (tx_in_ready_o !== 1'b1);
		end
		tx_in_valid_i <= 1'b0;
		tx_in_i.data <= ~f[f.size() - 1];
		repeat (f.size() + 10) @(posedge clk_i);
		check(mac.tx_seen.size(), exp.size());
		check(mac.tx_last_idx, exp.size() - 1);
		foreach (exp[i]) check(mac.tx_seen[i], exp[i]);
	endtask

	// watchdog, well beyond the few hundred cycles the tests need
	initial
	begin
		#50000;
		n_errors++;
		report_and_stop();
	end

	initial
	begin
		rst_n_i = 1'b0;
		{s_axi_awaddr_i, s_axi_araddr_i, s_axi_wdata_i} = '0;
		{s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i, s_axi_arvalid_i, s_axi_rready_i} = '0;
		s_axi_wstrb_i = 4'hf;
		{tx_cmd_valid_i, tx_in_valid_i} = '0;
		tx_cmd_i = '0;
		tx_in_i = '0;
		rows = '{'{8'h08, 32'hffff_ffff, 32'h0000_0000, RESP_OKAY},
			'{8'h0c, 32'hffff_ffff, 32'h0000_0000, RESP_SLVERR},
			'{8'h04, 32'h0000_9100, 32'h0000_9100, RESP_OKAY},
			'{8'h00, 32'hffff_ffff, 32'h0001_0003, RESP_OKAY},
			'{8'h00, 32'h0000_0000, 32'h0000_0000, RESP_OKAY}};
		repeat (20) @(posedge clk_i);
		rst_n_i <= 1'b1;
		// register rows: write, then read back
		foreach (rows[k])
		begin
			axi_wr(rows[k].addr, rows[k].wdata, rows[k].resp);
			axi_rd(rows[k].addr, rows[k].rdata, rows[k].resp);
		end
		// receive: pass-through, mode 0 with carries, mode 1 with snap, three tags
		mk(23);
		for (int i = 14; i < 18; i++) f[i] = 8'hff;
		rx_case(14, 1'b0);
		axi_wr(8'h00, 32'h0000_0001, RESP_OKAY);
		rx_case(14, 1'b1);
		axi_wr(8'h00, 32'h0000_0003, RESP_OKAY);
		mk(33);
		{f[12], f[13], f[16], f[17]} = 32'h9100_0010;
		rx_case(26, 1'b1);
		axi_wr(8'h04, 32'h0000_8100, RESP_OKAY);
		mk(30);
		{f[12], f[13], f[16], f[17], f[20], f[21]} = 48'h8100_8100_8100;
		rx_case(22, 1'b1);
		// transmit: odd start, zero result, missing conditions
		axi_wr(8'h00, 32'h0001_0000, RESP_OKAY);
		mk(24);
		tx_case(2'b11, 15, 18, 1'b1);
		for (int i = 14; i < 24; i++) f[i] = (i < 16) ? 8'hff : 8'h00;
		tx_case(2'b11, 14, 16, 1'b1);
		tx_case(2'b01, 14, 16, 1'b0);
		tx_case(2'b10, 14, 16, 1'b0);
		axi_wr(8'h00, 32'h0000_0000, RESP_OKAY);
		tx_case(2'b11, 14, 16, 1'b0);
		// second reset in mid-run restores the register reset values
		axi_wr(8'h04, 32'h0000_1234, RESP_OKAY);
		axi_wr(8'h00, 32'hffff_ffff, RESP_OKAY);
		rst_n_i <= 1'b0;
		@(posedge clk_i);
		check({s_axi_awready_o, s_axi_bvalid_o, tx_cmd_ready_o, tx_in_ready_o, tx_out_valid_o},
			5'b10100);
		rst_n_i <= 1'b1;
		axi_rd(8'h00, 32'h0000_0000, RESP_OKAY);
		axi_rd(8'h04, 32'h0000_8100, RESP_OKAY);
		report_and_stop();
	end
endmodule

bind csum_offload csum_offload_checker chk (.*);
